// ### step_direction_cfg.svh
// Constants for the three-channel step and direction generator
`ifndef STEP_DIRECTION_CFG_SVH
`define STEP_DIRECTION_CFG_SVH

// System clock and the step timebase, both in Hz
`define SYS_CLK_HZ 32'd40000000
`define STEP_CLK_HZ 32'd25000000

// Register indexes on both access paths
`define REG_STEP_RATE0 6'd18
`define REG_POSITION0 6'd21
`define REG_REMAINING0 6'd24
`define REG_STEP_LENGTH 6'd33

// Field layout
`define CHANNELS 3
`define WORD_W 32
`define PULSE_W 16
`define ACCESS_DATA_W 64
`define SIGN_BIT 31

// Reset values
`define RATE_RESET 32'h00000000
`define WIDTH_RESET 16'h0000
`define POSITION_RESET 32'h00000000
`define REMAINING_RESET 32'h00000000
`define PHASE_RESET 32'h00000000

`endif

// ### step_direction_pkg.sv
// Types shared by the step and direction generator
package step_direction_pkg;

  typedef struct packed {
    logic [31:0] phase;
    logic [15:0] pulse_cnt;
    logic step_level;
    logic [31:0] position;
    logic [31:0] remaining;
  } chan_state_t;

  typedef struct packed {
    logic [2:0][31:0] rate;
    logic [2:0][15:0] width;
    logic [31:0] tick_acc;
    logic tick;
    logic [63:0] net_rdata;
    logic [63:0] local_rdata;
  } gen_state_t;

endpackage

// ### step_channel.sv
// One step and direction channel: phase accumulator, pulse timer, counters
`timescale 1ns/1ps
`include "step_direction_cfg.svh"

module step_channel
  import step_direction_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic tick,
  input wire logic [31:0] rate,
  input wire logic [15:0] width,
  input wire logic target_wr,
  input wire logic [31:0] target_wdata,
  output logic step_out,
  output logic step_out_inverted,
  output logic direction_out,
  output logic direction_out_inverted,
  output logic [31:0] position,
  output logic [31:0] remaining
);

  chan_state_t s_r;
  chan_state_t s_nxt;
  logic [31:0] mag;
  logic [32:0] sum;
  logic fire;

  always_comb begin
    s_nxt = s_r;
    mag = rate[`SIGN_BIT] ? (~rate + 32'h00000001) : rate;
    sum = 33'h000000000;
    fire = 1'b0;
    if (tick) begin
      sum = {1'b0, s_r.phase} + {1'b0, mag};
      s_nxt.phase = sum[31:0];
      fire = sum[32] && (s_r.remaining != 32'h00000000);
      if (s_r.pulse_cnt != 16'h0000) begin
        s_nxt.pulse_cnt = s_r.pulse_cnt - 16'h0001;
      end
    end
    if (fire) begin
      s_nxt.remaining = s_r.remaining - 32'h00000001;
      s_nxt.position = rate[`SIGN_BIT] ? (s_r.position - 32'h00000001) : (s_r.position + 32'h00000001);
      // width of zero still gives one tick, so a step is never lost
      s_nxt.pulse_cnt = (width == 16'h0000) ? 16'h0001 : width;
    end
    // write wins over a step in the same cycle
    if (target_wr) begin
      s_nxt.remaining = target_wdata;
    end
    s_nxt.step_level = (s_nxt.pulse_cnt != 16'h0000);
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_r <= '{phase: `PHASE_RESET, pulse_cnt: 16'h0000, step_level: 1'b0,
               position: `POSITION_RESET, remaining: `REMAINING_RESET};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign step_out = s_r.step_level;
  assign step_out_inverted = ~s_r.step_level;
  assign direction_out = rate[`SIGN_BIT];
  assign direction_out_inverted = ~rate[`SIGN_BIT];
  assign position = s_r.position;
  assign remaining = s_r.remaining;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_step_fired;
    fire && !target_wr;
  endsequence

  sequence s_pulse_seen;
    step_out && !step_out_inverted;
  endsequence

  a_quiet_at_zero: assert property ((tick && remaining == 32'h0 && !target_wr) |=>
    (remaining == 32'h0) && $stable(position)) else $error("step taken with zero target");
  a_target_countdown: assert property (s_step_fired |=>
    remaining == $past(remaining) - 32'h1) else $error("remaining did not count down");
  a_position_tracks: assert property (fire |=>
    position == ($past(rate[31]) ? $past(position) - 32'h1 : $past(position) + 32'h1))
    else $error("position moved wrong way");
  a_target_reload: assert property (target_wr |=> remaining == $past(target_wdata))
    else $error("target write lost");
  a_pulse_follows: assert property (fire |=> s_pulse_seen)
    else $error("no pulse after step");
  a_inverse_pairs: assert property ((step_out_inverted == !step_out) &&
    (direction_out_inverted == !direction_out)) else $error("inverse output mismatch");
  a_dir_sign: assert property (direction_out == rate[31])
    else $error("direction not from sign");

endmodule

// ### step_direction_generator.sv
// Three-channel step and direction generator with two register access paths
`timescale 1ns/1ps
`include "step_direction_cfg.svh"

// What this block does
// - Three independent channels, 0 to 2, each with its own rate, counter, target and outputs.
// - Each channel holds a 32-bit two's complement rate whose magnitude sets the step interval.
// - Each direction pair follows the sign bit of its channel's rate.
// - Each channel's position counter moves up or down one per step by direction and is read-only.
// - Each channel's 32-bit remaining count drops by one with every emitted step.
// - A channel whose remaining count is zero emits no steps.
// - A new remaining count may be written at any time and stepping continues from it.
// - Reading the remaining register returns the steps still to go, not the last written value.
// - Both access paths write rates and targets and read counters in the same way.
// - Each channel's step pulse width is a 16-bit count of 25 MHz cycles.
module step_direction_generator
  import step_direction_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic net_wr,
  input wire logic net_rd,
  input wire logic [5:0] net_addr,
  input wire logic [63:0] net_wdata,
  output logic [63:0] net_rdata,
  input wire logic local_wr,
  input wire logic local_rd,
  input wire logic [5:0] local_addr,
  input wire logic [63:0] local_wdata,
  output logic [63:0] local_rdata,
  output logic step_out_ch0,
  output logic step_out_ch0_inverted,
  output logic direction_out_ch0,
  output logic direction_out_ch0_inverted,
  output logic step_out_ch1,
  output logic step_out_ch1_inverted,
  output logic direction_out_ch1,
  output logic direction_out_ch1_inverted,
  output logic step_out_ch2,
  output logic step_out_ch2_inverted,
  output logic direction_out_ch2,
  output logic direction_out_ch2_inverted
);

  gen_state_t s_r;
  gen_state_t s_nxt;
  logic [2:0] target_wr;
  logic [2:0][31:0] target_wdata;
  logic [2:0][31:0] position;
  logic [2:0][31:0] remaining;
  logic [2:0] step_level;
  logic [2:0] step_level_n;
  logic [2:0] dir_level;
  logic [2:0] dir_level_n;
  logic [32:0] tick_sum;

  // Counters live in the channels, so reads look there rather than at a copy
  function automatic logic [63:0] read_reg(input logic [5:0] addr,
                                           input logic [2:0][31:0] pos,
                                           input logic [2:0][31:0] rem);
    logic [63:0] val;
    val = 64'h0000000000000000;
    for (int i = 0; i < `CHANNELS; i++) begin
      if (addr == 6'(`REG_POSITION0 + i)) begin
        val = {32'h00000000, pos[i]};
      end
      if (addr == 6'(`REG_REMAINING0 + i)) begin
        val = {32'h00000000, rem[i]};
      end
    end
    return val;
  endfunction

  always_comb begin
    s_nxt = s_r;
    target_wr = 3'b000;
    target_wdata = '0;
    // 25 MHz timebase from the 40 MHz clock by fractional accumulation
    tick_sum = {1'b0, s_r.tick_acc} + {1'b0, `STEP_CLK_HZ};
    if (tick_sum >= {1'b0, `SYS_CLK_HZ}) begin
      s_nxt.tick_acc = 32'(tick_sum - {1'b0, `SYS_CLK_HZ});
      s_nxt.tick = 1'b1;
    end else begin
      s_nxt.tick_acc = tick_sum[31:0];
      s_nxt.tick = 1'b0;
    end
    // Network side takes precedence when both paths hit the same register together
    for (int i = 0; i < `CHANNELS; i++) begin
      if (net_wr && net_addr == 6'(`REG_STEP_RATE0 + i)) begin
        s_nxt.rate[i] = net_wdata[31:0];
      end else if (local_wr && local_addr == 6'(`REG_STEP_RATE0 + i)) begin
        s_nxt.rate[i] = local_wdata[31:0];
      end
      if (net_wr && net_addr == 6'(`REG_REMAINING0 + i)) begin
        target_wr[i] = 1'b1;
        target_wdata[i] = net_wdata[31:0];
      end else if (local_wr && local_addr == 6'(`REG_REMAINING0 + i)) begin
        target_wr[i] = 1'b1;
        target_wdata[i] = local_wdata[31:0];
      end
      if (net_wr && net_addr == `REG_STEP_LENGTH) begin
        s_nxt.width[i] = net_wdata[16 * i +: 16];
      end else if (local_wr && local_addr == `REG_STEP_LENGTH) begin
        s_nxt.width[i] = local_wdata[16 * i +: 16];
      end
    end
    if (net_rd) begin
      s_nxt.net_rdata = read_reg(net_addr, position, remaining);
    end
    if (local_rd) begin
      s_nxt.local_rdata = read_reg(local_addr, position, remaining);
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_r <= '{rate: {`RATE_RESET, `RATE_RESET, `RATE_RESET},
               width: {`WIDTH_RESET, `WIDTH_RESET, `WIDTH_RESET},
               tick_acc: 32'h00000000, tick: 1'b0,
               net_rdata: 64'h0000000000000000, local_rdata: 64'h0000000000000000};
    end else begin
      s_r <= s_nxt;
    end
  end

  for (genvar g = 0; g < `CHANNELS; g++) begin : chan
    step_channel u_channel (
      .clk(clk),
      .reset(reset),
      .tick(s_r.tick),
      .rate(s_r.rate[g]),
      .width(s_r.width[g]),
      .target_wr(target_wr[g]),
      .target_wdata(target_wdata[g]),
      .step_out(step_level[g]),
      .step_out_inverted(step_level_n[g]),
      .direction_out(dir_level[g]),
      .direction_out_inverted(dir_level_n[g]),
      .position(position[g]),
      .remaining(remaining[g])
    );
  end

  assign net_rdata = s_r.net_rdata;
  assign local_rdata = s_r.local_rdata;
  assign step_out_ch0 = step_level[0];
  assign step_out_ch0_inverted = step_level_n[0];
  assign direction_out_ch0 = dir_level[0];
  assign direction_out_ch0_inverted = dir_level_n[0];
  assign step_out_ch1 = step_level[1];
  assign step_out_ch1_inverted = step_level_n[1];
  assign direction_out_ch1 = dir_level[1];
  assign direction_out_ch1_inverted = dir_level_n[1];
  assign step_out_ch2 = step_level[2];
  assign step_out_ch2_inverted = step_level_n[2];
  assign direction_out_ch2 = dir_level[2];
  assign direction_out_ch2_inverted = dir_level_n[2];

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // Helper: ticks seen in each fixed, back-to-back window of eight clocks must be five
  logic [2:0] win_cnt;
  logic [3:0] win_ticks;
  logic win_done;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      win_cnt <= 3'h0;
      win_ticks <= 4'h0;
      win_done <= 1'b0;
    end else begin
      win_cnt <= win_cnt + 3'h1;
      win_ticks <= (win_cnt == 3'h7) ? 4'(s_r.tick) : win_ticks + 4'(s_r.tick);
      // Flag the window once its eighth sample is in, not as the count restarts
      win_done <= (win_cnt == 3'h6);
    end
  end

  sequence s_net_rate0_write;
    net_wr && net_addr == 6'h12;
  endsequence

  sequence s_local_rate1_only;
    local_wr && local_addr == 6'h13 && !(net_wr && net_addr == 6'h13);
  endsequence

  a_net_rate_write: assert property (s_net_rate0_write |=>
    s_r.rate[0] == $past(net_wdata[31:0])) else $error("network rate write lost");
  a_local_rate_write: assert property (s_local_rate1_only |=>
    s_r.rate[1] == $past(local_wdata[31:0])) else $error("local rate write lost");
  a_read_remaining: assert property ((local_rd && local_addr == 6'h18) |=>
    local_rdata == {32'h0, $past(remaining[0])}) else $error("remaining read wrong");
  a_read_position: assert property ((net_rd && net_addr == 6'h17) |=>
    net_rdata == {32'h0, $past(position[2])}) else $error("position read wrong");
  a_target_route: assert property ((net_wr && net_addr == 6'h1a) |->
    target_wr[2] && target_wdata[2] == net_wdata[31:0]) else $error("target write not routed");
  a_width_write: assert property ((local_wr && local_addr == 6'h21 && !net_wr) |=>
    s_r.width[2] == $past(local_wdata[47:32])) else $error("pulse width write lost");
  a_tick_ratio: assert property (win_done && $past(win_done, 8) |-> win_ticks == 4'h5)
    else $error("step timebase not five in eight");
  a_pins_inverse: assert property (step_out_ch1_inverted == !step_out_ch1 &&
    direction_out_ch2_inverted == !direction_out_ch2) else $error("pin pair not inverse");

endmodule

// ### motor_driver_model.sv
// Far-side stepper driver model: counts step edges signed by direction
`timescale 1ns/1ps
module motor_driver_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic step_in,
  input wire logic step_in_inverted,
  input wire logic dir_in,
  input wire logic dir_in_inverted,
  output logic [31:0] steps_seen,
  output logic pair_bad
);
  logic step_d;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      step_d <= 1'b0;
      steps_seen <= 32'h0;
      pair_bad <= 1'b0;
    end else begin
      step_d <= step_in;
      // Sticky so a single glitch between pair members is never missed
      if (step_in === step_in_inverted || dir_in === dir_in_inverted) begin
        pair_bad <= 1'b1;
      end
      // Real drivers act on the rising step edge with the direction then present
      if (step_in && !step_d) begin
        steps_seen <= dir_in ? steps_seen - 32'h1 : steps_seen + 32'h1;
      end
    end
  end
endmodule

// ### tb_top.sv
// Self-checking bench for the step and direction generator
`timescale 1ns/1ps
module tb_top;
  logic clk, reset, net_wr, net_rd, local_wr, local_rd;
  logic [5:0] net_addr, local_addr;
  logic [63:0] net_wdata, local_wdata, net_rdata, local_rdata;
  logic [2:0] st, st_n, dr, dr_n, bad;
  logic [31:0] seen [3];
  logic [31:0] pos [3];
  logic [31:0] seed;
  int failures, num_checks, cycles;

  step_direction_generator u_dut (.clk(clk), .reset(reset),
    .net_wr(net_wr), .net_rd(net_rd), .net_addr(net_addr), .net_wdata(net_wdata), .net_rdata(net_rdata),
    .local_wr(local_wr), .local_rd(local_rd), .local_addr(local_addr), .local_wdata(local_wdata),
    .local_rdata(local_rdata),
    .step_out_ch0(st[0]), .step_out_ch0_inverted(st_n[0]), .direction_out_ch0(dr[0]),
    .direction_out_ch0_inverted(dr_n[0]),
    .step_out_ch1(st[1]), .step_out_ch1_inverted(st_n[1]), .direction_out_ch1(dr[1]),
    .direction_out_ch1_inverted(dr_n[1]),
    .step_out_ch2(st[2]), .step_out_ch2_inverted(st_n[2]), .direction_out_ch2(dr[2]),
    .direction_out_ch2_inverted(dr_n[2]));

  for (genvar i = 0; i < 3; i++) begin : g_drv
    motor_driver_model u_drv (.clk(clk), .reset(reset), .step_in(st[i]), .step_in_inverted(st_n[i]),
      .dir_in(dr[i]), .dir_in_inverted(dr_n[i]), .steps_seen(seen[i]), .pair_bad(bad[i]));
  end

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [31:0] exp_pos(input logic [31:0] p, n, input logic neg);
    return neg ? p - n : p + n;
  endfunction

  task automatic results();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [63:0] exp, got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Both paths carry the same address and data; only the strobe picks the path
  task automatic wr(input bit loc, input logic [5:0] a, input logic [63:0] d);
    @(negedge clk);
    net_addr = a;
    local_addr = a;
    net_wdata = d;
    local_wdata = d;
    net_wr = !loc;
    local_wr = loc;
    @(negedge clk);
    net_wr = 1'b0;
    local_wr = 1'b0;
  endtask

  task automatic rd(input bit loc, input logic [5:0] a, output logic [63:0] d);
    @(negedge clk);
    net_addr = a;
    local_addr = a;
    net_rd = !loc;
    local_rd = loc;
    @(negedge clk);
    net_rd = 1'b0;
    local_rd = 1'b0;
    d = loc ? local_rdata : net_rdata;
  endtask

  task automatic move(input int ch, input bit loc, input logic [31:0] rate, n);
    logic [63:0] r;
    wr(loc, 6'd18 + 6'(ch), {32'h0, rate});
    wr(!loc, 6'd24 + 6'(ch), {32'h0, n});
    chk("direction", {62'h0, rate[31], ~rate[31]}, {62'h0, dr[ch], dr_n[ch]});
    repeat (16 * n + 32) @(negedge clk);
    pos[ch] = exp_pos(pos[ch], n, rate[31]);
    rd(loc, 6'd24 + 6'(ch), r);
    chk("remaining", 64'h0, r);
    rd(!loc, 6'd21 + 6'(ch), r);
    chk("position", {32'h0, pos[ch]}, r);
    chk("driver_steps", {32'h0, pos[ch]}, {32'h0, seen[ch]});
    $display("test move ch%0d n=%0d done", ch, n);
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 8000) begin
      failures++;
      $display("ERROR timeout expected done seen hang");
      results();
    end
  end

  initial begin
    logic [63:0] r;
    logic [31:0] m, s;
    seed = 32'h6e87;
    {net_wr, net_rd, local_wr, local_rd} = 4'h0;
    {net_addr, local_addr} = 12'h0;
    {net_wdata, local_wdata} = 128'h0;
    pos = '{32'h0, 32'h0, 32'h0};
    reset = 1'b1;
    repeat (8) @(posedge clk);
    @(negedge clk);
    reset = 1'b0;
    chk("reset_pins", {12'h0, 3'h0, 3'h7, 3'h0, 3'h7}, {12'h0, st, st_n, dr, dr_n});
    rd(1'b0, 6'd21, r);
    chk("reset_position", 64'h0, r);
    rd(1'b1, 6'd18, r);
    chk("rate_readback", 64'h0, r);
    rd(1'b0, 6'h3f, r);
    chk("unmapped", 64'h0, r);
    // One-tick pulses on ch0 and ch2, zero (one tick) on ch1; spacing is at least two ticks
    wr(1'b1, 6'd33, 64'h0000_0001_0000_0001);
    wr(1'b0, 6'd21, 64'h1234);
    rd(1'b1, 6'd21, r);
    chk("position_ro", 64'h0, r);
    $display("test registers done");
    move(0, 1'b0, 32'h8000_0000, 32'h2);
    for (int i = 0; i < 6; i++) begin
      m = 32'h4000_0000 | (rnd() & 32'h3fff_ffff);
      s = rnd();
      move(i % 3, s[1], s[0] ? -m : m, 32'h1 + (rnd() & 32'h7));
    end
    // Stop a long move part way, then restart it with a short count
    wr(1'b0, 6'd20, 64'h8000_0000 >> 1);
    wr(1'b1, 6'd26, 64'd100);
    repeat (40) @(negedge clk);
    rd(1'b0, 6'd26, r);
    chk("mid_remaining", 64'h1, {63'h0, r > 64'd0 && r < 64'd100});
    wr(1'b1, 6'd26, 64'h0);
    repeat (20) @(negedge clk);
    s = seen[2];
    rd(1'b0, 6'd26, r);
    chk("stopped", 64'h0, r);
    wr(1'b0, 6'd26, 64'd5);
    repeat (120) @(negedge clk);
    chk("restart_steps", {32'h0, s + 32'd5}, {32'h0, seen[2]});
    rd(1'b1, 6'd23, r);
    chk("restart_position", {32'h0, s + 32'd5}, r);
    chk("pairs", 64'h0, {61'h0, bad});
    $display("test rewrite done");
    results();
  end
endmodule
